/* rtl/tugsc_pkg.sv */
// Purpose: shared constants for the trigger unit global status bank
// Assumes: apb word access, one register per aligned 32-bit word
// Notes: printed offsets are register indices; byte address is index * 4
package tugsc_pkg;
  // ==========================================================
  // register indices and byte addresses
  localparam int unsigned ADDR_W = 14;
  localparam logic [11:0] IDX_ERROR = 12'h200;
  localparam logic [11:0] IDX_ACTIVE = 12'h202;
  localparam logic [11:0] IDX_DONE = 12'h204;
  localparam logic [11:0] IDX_ENABLE = 12'h206;
  localparam logic [11:0] IDX_SRST = 12'h208;
  localparam logic [11:0] IDX_MASK = 12'h20C;
  localparam logic [11:0] IDX_PEND = 12'h20E;
  localparam logic [13:0] ADR_ERROR = {IDX_ERROR, 2'h0};
  localparam logic [13:0] ADR_ACTIVE = {IDX_ACTIVE, 2'h0};
  localparam logic [13:0] ADR_DONE = {IDX_DONE, 2'h0};
  localparam logic [13:0] ADR_ENABLE = {IDX_ENABLE, 2'h0};
  localparam logic [13:0] ADR_SRST = {IDX_SRST, 2'h0};
  localparam logic [13:0] ADR_MASK = {IDX_MASK, 2'h0};
  localparam logic [13:0] ADR_PEND = {IDX_PEND, 2'h0};
  // ==========================================================
  // field layout and reset values
  localparam int unsigned UNITS_MAX = 12;
  localparam int unsigned SUMMARY_BIT = 16;
  localparam logic [11:0] FLAGS_RESET = 12'h000;
endpackage : tugsc_pkg

/* rtl/tugsc_bank.sv */
// Purpose: global status and control bank for the trigger output units
// Assumes: single clock mclk, synchronous active high rst, apb slave
// Notes: zero wait states; read data is captured in the setup cycle
// Notes: mask and pending words sit in reserved space next to the bank
// Notes: units outside this block own time compare and pulse shaping
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
module tugsc_bank #(
  parameter int unsigned NU = 12 // number of trigger units served
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tugsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NU-1:0] unit_fire, // pulse: unit made its trigger
  input wire logic [NU-1:0] unit_late, // level: target time already past
  input wire logic [NU-1:0] event_notify_option, // per-unit notify
  output logic [NU-1:0] unit_enable, // run permission to each unit
  output logic [NU-1:0] unit_soft_reset, // one-cycle unit reset pulse
  output logic [NU-1:0] unit_active, // per-unit active status
  output logic trigger_status, // sticky summary of any unit event
  output logic irq // level interrupt to the host
);
  // ==========================================================
  // elaboration check
  // a count above twelve would spill into the reserved bits
  if (NU < 1 || NU > tugsc_pkg::UNITS_MAX) begin : g_bad_nu
    $error("unit count out of range");
  end

  // ==========================================================
  // state
  // one packed word so every flag is reset and registered together
  typedef struct packed {
    logic [NU-1:0] en; // unit enable bits
    logic [NU-1:0] err; // unit error flags
    logic [NU-1:0] done; // unit done flags
    logic [NU-1:0] srst; // soft reset bits, live one cycle
    logic [NU-1:0] mask; // trigger_irq_mask
    logic [NU-1:0] pend; // trigger_irq_pending per unit
    logic summ; // summary status bit
    logic [31:0] rdata; // read data captured in setup
  } tugsc_state_s;

  tugsc_state_s st; // registered state
  tugsc_state_s next_st; // next state
  logic [NU-1:0] wd; // write data for the unit bits
  logic [NU-1:0] fire_ok; // trigger accepted from an enabled unit
  logic [NU-1:0] late_ok; // new error condition
  logic [NU-1:0] done_set; // new done event
  logic [NU-1:0] evt; // any unit event this cycle
  logic wr; // write access phase
  logic rd_setup; // read setup phase
  logic hit_any; // address decodes to a register

  // ==========================================================
  // decode and unit events
  // pure decode of the bus request and the raw unit inputs,
  // kept apart so the next-state process stays readable
  always_comb begin
    wd = pwdata[NU-1:0];
    wr = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    // only the seven mapped words answer without an error
    hit_any = (paddr == tugsc_pkg::ADR_ERROR) ||
              (paddr == tugsc_pkg::ADR_ACTIVE) ||
              (paddr == tugsc_pkg::ADR_DONE) ||
              (paddr == tugsc_pkg::ADR_ENABLE) ||
              (paddr == tugsc_pkg::ADR_SRST) ||
              (paddr == tugsc_pkg::ADR_MASK) ||
              (paddr == tugsc_pkg::ADR_PEND);
    // a unit in reset or disabled cannot report anything
    fire_ok = unit_fire & st.en & ~st.srst;
    late_ok = unit_late & event_notify_option & st.en & ~st.err &
              ~st.srst;
    done_set = fire_ok & event_notify_option;
    evt = done_set | late_ok;
  end

  // ==========================================================
  // next state
  // updates are layered in priority order: software writes first,
  // hardware sets after them, a live soft reset last of all
  always_comb begin
    next_st = st;
    next_st.srst = '0;
    // enable: software writes, trigger clears
    if (wr && paddr == tugsc_pkg::ADR_ENABLE) begin
      next_st.en = wd;
      next_st.err = st.err & wd;
    end
    next_st.en = next_st.en & ~fire_ok;
    // error set wins over a same-cycle clearing write
    next_st.err = next_st.err | late_ok;
    // done is write-one-to-clear, zeros leave it alone
    if (wr && paddr == tugsc_pkg::ADR_DONE) begin
      next_st.done = st.done & ~wd;
    end
    next_st.done = next_st.done | done_set;
    if (wr && paddr == tugsc_pkg::ADR_SRST) begin
      next_st.srst = wd;
    end
    // interrupt mask, plain read and write
    if (wr && paddr == tugsc_pkg::ADR_MASK) begin
      next_st.mask = wd;
    end
    // pending word: unit bits and summary are write-one-to-clear,
    // and a unit event in the same cycle wins over the clear
    if (wr && paddr == tugsc_pkg::ADR_PEND) begin
      next_st.pend = st.pend & ~wd;
      if (pwdata[tugsc_pkg::SUMMARY_BIT]) begin
        next_st.summ = 1'h0;
      end
    end
    next_st.pend = next_st.pend | evt;
    next_st.summ = next_st.summ | (|evt);
    // a pending soft reset returns its units to idle defaults;
    // this stops a looping cascade because the unit loses enable
    next_st.en = next_st.en & ~st.srst;
    next_st.err = next_st.err & ~st.srst;
    next_st.done = next_st.done & ~st.srst;
    // read data is fetched in setup so it stands through access
    if (rd_setup) begin
      // zero first so bits above the unit count read zero, except the summary bit of the pending word
      next_st.rdata = '0;
      unique case (paddr)
        tugsc_pkg::ADR_ERROR: next_st.rdata[NU-1:0] = st.err;
        tugsc_pkg::ADR_ACTIVE:
          next_st.rdata[NU-1:0] = st.en & ~st.err;
        tugsc_pkg::ADR_DONE: next_st.rdata[NU-1:0] = st.done;
        tugsc_pkg::ADR_ENABLE: next_st.rdata[NU-1:0] = st.en;
        tugsc_pkg::ADR_SRST: next_st.rdata[NU-1:0] = st.srst;
        tugsc_pkg::ADR_MASK: next_st.rdata[NU-1:0] = st.mask;
        tugsc_pkg::ADR_PEND: begin
          next_st.rdata[NU-1:0] = st.pend;
          next_st.rdata[tugsc_pkg::SUMMARY_BIT] = st.summ;
        end
        default: next_st.rdata = '0; // unmapped reads zero
      endcase
    end
  end

  // ==========================================================
  // registers
  // synchronous reset: every flag, mask and pending bit returns
  // to zero, so the host sees a quiet bank after reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = st.rdata;
  assign pready = 1'h1; // never waits, access phase is one cycle
  assign pslverr = psel && penable && !hit_any;
  // enable is masked by a live soft reset, so a unit never runs
  // in the cycle in which its reset pulse stands
  assign unit_enable = st.en & ~st.srst;
  assign unit_soft_reset = st.srst;
  assign unit_active = st.en & ~st.err;
  assign trigger_status = st.summ;
  // level interrupt: stays high until software clears pending or the mask bit
  assign irq = |(st.pend & st.mask);

  // ==========================================================
  // checks
  // all checks share the one clock; reset disables all but p_reset_idle
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_err_set;
    (late_ok != '0) |=> ((st.err & $past(late_ok)) == $past(late_ok));
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("late unit did not flag error");

  property p_err_clr;
    (wr && paddr == tugsc_pkg::ADR_ENABLE && late_ok == '0)
      |=> ((st.err & ~$past(wd)) == '0);
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error bit survived enable write of zero");

  property p_active_on;
    (wr && paddr == tugsc_pkg::ADR_ENABLE && st.err == '0 &&
     st.srst == '0 && unit_fire == '0 && unit_late == '0)
      |=> ((unit_active & $past(wd)) == $past(wd));
  endproperty
  a_active_on: assert property (p_active_on)
    else $error("enabled unit not active");

  property p_active_off;
    (fire_ok != '0) |=> ((unit_active & $past(fire_ok)) == '0);
  endproperty
  a_active_off: assert property (p_active_off)
    else $error("finished unit still active");

  property p_done_irq;
    (done_set != '0 && (done_set & st.mask) != '0 &&
     !(wr && paddr == tugsc_pkg::ADR_MASK)) |=> ##[0:1] irq;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("masked-in done gave no interrupt");

  property p_done_reset;
    $fell(rst) |-> (st.done == '0 && irq == 1'h0);
  endproperty
  a_done_reset: assert property (p_done_reset)
    else $error("done flags not clear after reset");

  property p_en_selfclr;
    (fire_ok != '0) |=> ((st.en & $past(fire_ok)) == '0);
  endproperty
  a_en_selfclr: assert property (p_en_selfclr)
    else $error("enable did not self clear");

  property p_srst_pulse;
    (wr && paddr == tugsc_pkg::ADR_SRST && wd != '0)
      |=> (st.srst == $past(wd)) ##1 ((st.srst & $past(st.srst)) == '0
      && (st.en & $past(st.srst)) == '0);
  endproperty
  a_srst_pulse: assert property (p_srst_pulse)
    else $error("soft reset did not pulse and idle unit");

  property p_summary;
    (evt != '0) |=> trigger_status;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary status not set");

  property p_upper_zero;
    (psel && penable && !pwrite) |-> (prdata[15:NU] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved bits read nonzero");

  // a done-clear write of zeros must leave every done flag alone
  property p_done_zero_write;
    (wr && paddr == tugsc_pkg::ADR_DONE && wd == '0 &&
     done_set == '0 && st.srst == '0)
      |=> (st.done == $past(st.done));
  endproperty
  a_done_zero_write: assert property (p_done_zero_write)
    else $error("done flags changed on a zero write");

  // a trigger from a unit without run permission changes no done flag
  property p_idle_silent;
    (unit_fire != '0 && (unit_fire & unit_enable) == '0 &&
     st.srst == '0 && !(wr && paddr == tugsc_pkg::ADR_DONE))
      |=> $stable(st.done);
  endproperty
  a_idle_silent: assert property (p_idle_silent)
    else $error("disabled unit reported a trigger");

  // writing the summary bit clears it when no unit event competes
  property p_summary_clr;
    (wr && paddr == tugsc_pkg::ADR_PEND &&
     pwdata[tugsc_pkg::SUMMARY_BIT] && evt == '0) |=> !trigger_status;
  endproperty
  a_summary_clr: assert property (p_summary_clr)
    else $error("summary status survived a clearing write");

  // a synchronous reset leaves every unit idle and the host quiet
  property p_reset_idle;
    disable iff (1'h0)
      rst |=> (unit_enable == '0 && unit_soft_reset == '0 &&
      !trigger_status && !irq);
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");

  // a reset pulse leaves its units idle and ready for new settings
  property p_srst_ready;
    (st.srst != '0) |=> (((st.en | st.err | st.done) & $past(st.srst))
      == '0);
  endproperty
  a_srst_ready: assert property (p_srst_ready)
    else $error("soft reset left a unit busy or flagged");

  // main scenarios: done with interrupt, error, soft reset, clear
  c_done: cover property (done_set != '0 ##1 irq);
  c_err: cover property (late_ok != '0 ##1 st.err != '0);
  c_srst: cover property (st.srst != '0 && st.en != '0);
  c_late_irq: cover property (st.err != '0 && irq);
  c_summ_clr: cover property (trigger_status ##1 !trigger_status);
endmodule : tugsc_bank

/* sim/tugsc_tb.sv */
// Purpose: self-checking bench for the trigger unit status bank
// Assumes: apb slave, notify high on all units but in the notify-off test
// Notes: table rows first, then hand-written event and refusal tests
`timescale 1ns/1ns
module tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, tst, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] fire, late, notify, en_o, srst_o, act_o;
  int num_errors = 0;
  int total_checks = 0;
  // one row: write flag, address, write data or expected read data
  typedef struct {bit w; logic [13:0] a; logic [31:0] d;} tugsc_row_s;
  tugsc_row_s rows[13] = '{
    '{0, tugsc_pkg::ADR_ERROR, 32'h0}, '{0, tugsc_pkg::ADR_ACTIVE, 32'h0},
    '{0, tugsc_pkg::ADR_DONE, 32'h0}, '{0, tugsc_pkg::ADR_ENABLE, 32'h0},
    '{0, tugsc_pkg::ADR_SRST, 32'h0},
    '{1, tugsc_pkg::ADR_ENABLE, 32'hFFFFFFFF},
    '{0, tugsc_pkg::ADR_ENABLE, 32'hFFF}, '{0, tugsc_pkg::ADR_ACTIVE, 32'hFFF},
    '{1, tugsc_pkg::ADR_SRST, 32'h1}, '{0, tugsc_pkg::ADR_SRST, 32'h0},
    '{0, tugsc_pkg::ADR_ENABLE, 32'hFFE},
    '{1, tugsc_pkg::ADR_ENABLE, 32'h0}, '{0, tugsc_pkg::ADR_ACTIVE, 32'h0}};

  tugsc_bank dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_fire(fire),
    .unit_late(late), .event_notify_option(notify), .unit_enable(en_o),
    .unit_soft_reset(srst_o), .unit_active(act_o),
    .trigger_status(tst), .irq(irq));

  // ==========================================================
  // clock, 100 ns period
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // apb transfer; request held until pready seen high at an edge
  task apb(input bit w, input logic [13:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // wait states end only at pready; the watchdog bounds a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle event pulse, then let the flags settle
  task pulse(input logic [11:0] f, input logic [11:0] l);
    @(posedge mclk);
    fire <= f; late <= l;
    @(posedge mclk);
    fire <= 12'h0; late <= 12'h0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : pulse

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  initial begin
    rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 14'h0;
    pwdata = 32'h0; fire = 12'h0; late = 12'h0; notify = 12'hFFF;
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    chk({irq, tst, en_o, act_o}, 32'h0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].d);
    end
    $display("test table finished");
    // fire on units 1..3, unit 3 not enabled; mask unit 1
    apb(1, tugsc_pkg::ADR_MASK, 32'h1);
    apb(1, tugsc_pkg::ADR_ENABLE, 32'h3);
    pulse(12'h7, 12'h0);
    chk(en_o, 32'h0);
    apb(0, tugsc_pkg::ADR_DONE, 32'h0);
    chk(rd, 32'h3);
    chk({tst, irq}, 32'h3);
    apb(0, tugsc_pkg::ADR_PEND, 32'h0);
    chk(rd, 32'h00010003);
    apb(1, tugsc_pkg::ADR_MASK, 32'h0);
    @(negedge mclk);
    chk(irq, 32'h0);
    apb(1, tugsc_pkg::ADR_DONE, 32'h0);
    apb(0, tugsc_pkg::ADR_DONE, 32'h0);
    chk(rd, 32'h3);
    apb(1, tugsc_pkg::ADR_DONE, 32'h1);
    apb(0, tugsc_pkg::ADR_DONE, 32'h0);
    chk(rd, 32'h2);
    $display("test done flags finished");
    // late target on enabled unit 5
    apb(1, tugsc_pkg::ADR_ENABLE, 32'h10);
    pulse(12'h0, 12'h10);
    apb(0, tugsc_pkg::ADR_ERROR, 32'h0);
    chk(rd, 32'h10);
    chk(act_o, 32'h0);
    apb(1, tugsc_pkg::ADR_MASK, 32'h10);
    @(negedge mclk);
    chk(irq, 32'h1);
    apb(1, tugsc_pkg::ADR_ENABLE, 32'h0);
    apb(0, tugsc_pkg::ADR_ERROR, 32'h0);
    chk(rd, 32'h0);
    apb(1, tugsc_pkg::ADR_PEND, 32'h00010FFF);
    @(negedge mclk);
    chk({tst, irq}, 32'h0);
    $display("test error flag finished");
    // soft reset stops unit 12; a later fire must be ignored
    apb(1, tugsc_pkg::ADR_ENABLE, 32'h800);
    apb(1, tugsc_pkg::ADR_SRST, 32'h800);
    @(negedge mclk);
    chk(srst_o, 32'h800);
    pulse(12'h800, 12'h0);
    chk({en_o, act_o}, 32'h0);
    apb(0, tugsc_pkg::ADR_DONE, 32'h0);
    chk(rd, 32'h2);
    // notify off on unit 1: late and trigger leave no flag behind
    notify <= 12'hFFE;
    apb(1, tugsc_pkg::ADR_ENABLE, 32'h1);
    pulse(12'h0, 12'h1);
    chk(act_o, 32'h1);
    apb(0, tugsc_pkg::ADR_ERROR, 32'h0);
    chk(rd, 32'h0);
    pulse(12'h1, 12'h0);
    chk(en_o, 32'h0);
    apb(0, tugsc_pkg::ADR_DONE, 32'h0);
    chk(rd, 32'h2);
    notify <= 12'hFFF;
    $display("test notify off finished");
    // unmapped word is refused and reads zero
    apb(0, 14'h3FFC, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    // second reset in mid-run
    apb(1, tugsc_pkg::ADR_ENABLE, 32'h3);
    @(posedge mclk);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    chk({irq, tst, en_o, act_o}, 32'h0);
    apb(0, tugsc_pkg::ADR_ENABLE, 32'h0);
    chk(rd, 32'h0);
    $display("test refusal and reset finished");
    give_verdict();
  end
endmodule : tb
